//--- inc/isr_pkg.sv
// package: register indices, flag positions and shared carrier types for the serializer data/irq bank
package isr_pkg;
  localparam int ISR_DW = 16;
  localparam int ISR_AW = 4;
  // register indices on the word-wide cpu port (dma uses channel pairs)
  localparam logic [3:0] ISR_IDX_TX_LEFT_LOW = 4'h0;
  localparam logic [3:0] ISR_IDX_TX_LEFT_HIGH = 4'h1;
  localparam logic [3:0] ISR_IDX_TX_RIGHT_LOW = 4'h2;
  localparam logic [3:0] ISR_IDX_TX_RIGHT_HIGH = 4'h3;
  localparam logic [3:0] ISR_IDX_IRQ_FLAGS = 4'h4;
  localparam logic [3:0] ISR_IDX_IRQ_ENABLES = 4'h5;
  localparam logic [3:0] ISR_IDX_RX_LEFT_LOW = 4'h8;
  localparam logic [3:0] ISR_IDX_RX_LEFT_HIGH = 4'h9;
  localparam logic [3:0] ISR_IDX_RX_RIGHT_LOW = 4'hA;
  localparam logic [3:0] ISR_IDX_RX_RIGHT_HIGH = 4'hB;
  // dma channel selectors
  localparam logic [1:0] ISR_DMA_TX_LEFT = 2'h0;
  localparam logic [1:0] ISR_DMA_TX_RIGHT = 2'h1;
  localparam logic [1:0] ISR_DMA_RX_LEFT = 2'h2;
  localparam logic [1:0] ISR_DMA_RX_RIGHT = 2'h3;
  // flag / enable bit positions
  localparam int ISR_BIT_STEREO_TX = 5;
  localparam int ISR_BIT_MONO_TX = 4;
  localparam int ISR_BIT_STEREO_RX = 3;
  localparam int ISR_BIT_MONO_RX = 2;
  localparam int ISR_BIT_FRAME_ERR = 1;
  localparam int ISR_BIT_OVER_UNDER = 0;
  localparam int ISR_NFLAGS = 6;
  localparam logic [15:0] ISR_RESET_WORD = 16'h0000;
  localparam logic [5:0] ISR_RESET_FLAGS = 6'h00;

  typedef struct packed {
    logic tx_need;
    logic rx_ready;
    logic frame_err;
    logic over_under;
  } isr_events_s;

  typedef struct packed {
    logic [31:0] left;
    logic [31:0] right;
  } isr_pair_s;
endpackage

//--- rtl/isr_flag_bit.sv
// one sticky clear-on-read flag bit with set-over-clear priority
`timescale 1ns/1ps
module isr_flag_bit
  import isr_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic set_i,
  input wire logic clear_i,
  output logic flag_o
);
  logic next_flag;

  always_comb
  begin
    next_flag = flag_o;
    if (clear_i)
    begin
      next_flag = 1'b0;
    end
    // an event in the clearing cycle survives
    if (set_i)
    begin
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      flag_o <= 1'b0;
    end
    else
    begin
      flag_o <= next_flag;
    end
  end
endmodule

//--- rtl/isr_regs.sv
// data holding registers and interrupt flag/enable registers of the audio serializer
//
// Functional notes
// RL1: two 32-bit tx holders, cpu halves
// RL2: two 32-bit rx holders, cpu halves
// RL3: dma moves whole 32-bit words
// RL4: tx half 0 low, half 1 high
// RL5: rx left low half, rw, resets zero
// RL6: rx high halves upper bits, right likewise
// RL7: tx halves rw, full range, reset zero
// RL8: stereo tx need sets bit 5
// RL9: mono tx need sets bit 4
// RL10: stereo rx ready sets bit 3
// RL11: mono rx ready sets bit 2
// RL12: frame sync error sets bit 1
// RL13: overrun or underrun sets bit 0
// RL14: flags read-only, cleared by reading
// RL15: enable 5 gates stereo tx irq
// RL16: enable 4 gates mono tx irq
// RL17: enables 3, 2 gate rx irqs
// RL18: enables 1, 0 gate errors, reset zero
// RL19: stereo service writes all four tx halves
// RL20: mono service writes left tx halves
// RL21: service reads rx halves per mode
// RL22: bits 15..6 read zero
// RL23: irq when flag and enable coincide
`timescale 1ns/1ps
module isr_regs
  import isr_pkg::*;
#(
  parameter int DW = ISR_DW,
  parameter int AW = ISR_AW
)
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  // cpu 16-bit register port
  input wire logic cpu_sel_i,
  input wire logic cpu_we_i,
  input wire logic [AW-1:0] cpu_addr_i,
  input wire logic [DW-1:0] cpu_wdata_i,
  output logic [DW-1:0] cpu_rdata_o,
  output logic cpu_ack_o,
  // dma 32-bit port
  input wire logic dma_sel_i,
  input wire logic dma_we_i,
  input wire logic [1:0] dma_chan_i,
  input wire logic [31:0] dma_wdata_i,
  output logic [31:0] dma_rdata_o,
  output logic dma_ack_o,
  // serializer side
  input wire logic mono_i,
  input wire isr_events_s events_i,
  input wire isr_pair_s rx_sample_i,
  input wire logic rx_load_i,
  output isr_pair_s tx_sample_o,
  output logic irq_o
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [DW-1:0] tx_left_low, tx_left_high, tx_right_low, tx_right_high;
  logic [DW-1:0] rx_left_low, rx_left_high, rx_right_low, rx_right_high;
  logic [ISR_NFLAGS-1:0] irq_enables;
  logic [ISR_NFLAGS-1:0] irq_flags;
  logic [DW-1:0] next_tx_left_low, next_tx_left_high, next_tx_right_low, next_tx_right_high;
  logic [DW-1:0] next_rx_left_low, next_rx_left_high, next_rx_right_low, next_rx_right_high;
  logic [ISR_NFLAGS-1:0] next_irq_enables;
  logic [DW-1:0] next_cpu_rdata;
  logic [31:0] next_dma_rdata;
  logic [ISR_NFLAGS-1:0] flag_set;
  logic [ISR_NFLAGS-1:0] flag_clear;
  logic cpu_wr, cpu_rd, dma_wr, dma_rd;

  assign cpu_wr = cpu_sel_i && cpu_we_i;
  assign cpu_rd = cpu_sel_i && !cpu_we_i;
  assign dma_wr = dma_sel_i && dma_we_i;
  assign dma_rd = dma_sel_i && !dma_we_i;

  // ----------------------------------------------------------------
  // flag sources
  // ----------------------------------------------------------------
  always_comb
  begin
    flag_set = '0;
    // RL8: stereo tx request
    flag_set[ISR_BIT_STEREO_TX] = events_i.tx_need && !mono_i;
    // RL9: mono tx request
    flag_set[ISR_BIT_MONO_TX] = events_i.tx_need && mono_i;
    // RL10: stereo rx ready
    flag_set[ISR_BIT_STEREO_RX] = events_i.rx_ready && !mono_i;
    // RL11: mono rx ready
    flag_set[ISR_BIT_MONO_RX] = events_i.rx_ready && mono_i;
    // RL12: frame sync error
    flag_set[ISR_BIT_FRAME_ERR] = events_i.frame_err;
    // RL13: over or under run
    flag_set[ISR_BIT_OVER_UNDER] = events_i.over_under;
  end

  // RL14: clear on flag read
  assign flag_clear = {ISR_NFLAGS{cpu_rd && (cpu_addr_i == ISR_IDX_IRQ_FLAGS[AW-1:0])}};

  genvar gi;
  generate
    for (gi = 0; gi < ISR_NFLAGS; gi++)
    begin : g_flag
      isr_flag_bit u_flag (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .set_i(flag_set[gi]),
        .clear_i(flag_clear[gi]),
        .flag_o(irq_flags[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_comb
  begin
    next_tx_left_low = tx_left_low;
    next_tx_left_high = tx_left_high;
    next_tx_right_low = tx_right_low;
    next_tx_right_high = tx_right_high;
    next_rx_left_low = rx_left_low;
    next_rx_left_high = rx_left_high;
    next_rx_right_low = rx_right_low;
    next_rx_right_high = rx_right_high;
    next_irq_enables = irq_enables;
    // newly received words land first; a software write in the same cycle wins after
    if (rx_load_i)
    begin
      // RL6: upper halves hold upper bits
      {next_rx_left_high, next_rx_left_low} = rx_sample_i.left;
      {next_rx_right_high, next_rx_right_low} = rx_sample_i.right;
    end
    if (cpu_wr)
    begin
      case (cpu_addr_i)
        // RL7: tx halves full range
        ISR_IDX_TX_LEFT_LOW[AW-1:0]: next_tx_left_low = cpu_wdata_i;
        ISR_IDX_TX_LEFT_HIGH[AW-1:0]: next_tx_left_high = cpu_wdata_i;
        ISR_IDX_TX_RIGHT_LOW[AW-1:0]: next_tx_right_low = cpu_wdata_i;
        ISR_IDX_TX_RIGHT_HIGH[AW-1:0]: next_tx_right_high = cpu_wdata_i;
        // RL18: enables read/write
        ISR_IDX_IRQ_ENABLES[AW-1:0]: next_irq_enables = cpu_wdata_i[ISR_NFLAGS-1:0];
        // RL5: rx halves writable
        ISR_IDX_RX_LEFT_LOW[AW-1:0]: next_rx_left_low = cpu_wdata_i;
        ISR_IDX_RX_LEFT_HIGH[AW-1:0]: next_rx_left_high = cpu_wdata_i;
        ISR_IDX_RX_RIGHT_LOW[AW-1:0]: next_rx_right_low = cpu_wdata_i;
        ISR_IDX_RX_RIGHT_HIGH[AW-1:0]: next_rx_right_high = cpu_wdata_i;
        default: next_irq_enables = irq_enables;
      endcase
    end
    // RL3: dma whole word write
    if (dma_wr)
    begin
      case (dma_chan_i)
        // RL4: low half gets bits 15..0
        ISR_DMA_TX_LEFT: {next_tx_left_high, next_tx_left_low} = dma_wdata_i;
        ISR_DMA_TX_RIGHT: {next_tx_right_high, next_tx_right_low} = dma_wdata_i;
        ISR_DMA_RX_LEFT: {next_rx_left_high, next_rx_left_low} = dma_wdata_i;
        ISR_DMA_RX_RIGHT: {next_rx_right_high, next_rx_right_low} = dma_wdata_i;
        default: next_irq_enables = next_irq_enables;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_comb
  begin
    next_cpu_rdata = cpu_rdata_o;
    if (cpu_rd)
    begin
      case (cpu_addr_i)
        // RL1: cpu sees tx halves
        ISR_IDX_TX_LEFT_LOW[AW-1:0]: next_cpu_rdata = tx_left_low;
        ISR_IDX_TX_LEFT_HIGH[AW-1:0]: next_cpu_rdata = tx_left_high;
        ISR_IDX_TX_RIGHT_LOW[AW-1:0]: next_cpu_rdata = tx_right_low;
        ISR_IDX_TX_RIGHT_HIGH[AW-1:0]: next_cpu_rdata = tx_right_high;
        // RL22: reserved bits zero
        ISR_IDX_IRQ_FLAGS[AW-1:0]: next_cpu_rdata = {{(DW-ISR_NFLAGS){1'b0}}, irq_flags};
        ISR_IDX_IRQ_ENABLES[AW-1:0]: next_cpu_rdata = {{(DW-ISR_NFLAGS){1'b0}}, irq_enables};
        // RL2: cpu sees rx halves
        ISR_IDX_RX_LEFT_LOW[AW-1:0]: next_cpu_rdata = rx_left_low;
        ISR_IDX_RX_LEFT_HIGH[AW-1:0]: next_cpu_rdata = rx_left_high;
        ISR_IDX_RX_RIGHT_LOW[AW-1:0]: next_cpu_rdata = rx_right_low;
        ISR_IDX_RX_RIGHT_HIGH[AW-1:0]: next_cpu_rdata = rx_right_high;
        // unmapped indices answer zero
        default: next_cpu_rdata = ISR_RESET_WORD;
      endcase
    end
  end

  always_comb
  begin
    next_dma_rdata = dma_rdata_o;
    // RL3: dma whole word read
    if (dma_rd)
    begin
      case (dma_chan_i)
        ISR_DMA_TX_LEFT: next_dma_rdata = {tx_left_high, tx_left_low};
        ISR_DMA_TX_RIGHT: next_dma_rdata = {tx_right_high, tx_right_low};
        ISR_DMA_RX_LEFT: next_dma_rdata = {rx_left_high, rx_left_low};
        ISR_DMA_RX_RIGHT: next_dma_rdata = {rx_right_high, rx_right_low};
        default: next_dma_rdata = dma_rdata_o;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      // RL7: everything resets to zero
      tx_left_low <= ISR_RESET_WORD;
      tx_left_high <= ISR_RESET_WORD;
      tx_right_low <= ISR_RESET_WORD;
      tx_right_high <= ISR_RESET_WORD;
      rx_left_low <= ISR_RESET_WORD;
      rx_left_high <= ISR_RESET_WORD;
      rx_right_low <= ISR_RESET_WORD;
      rx_right_high <= ISR_RESET_WORD;
      irq_enables <= ISR_RESET_FLAGS;
      cpu_rdata_o <= ISR_RESET_WORD;
      dma_rdata_o <= '0;
      cpu_ack_o <= 1'b0;
      dma_ack_o <= 1'b0;
      tx_sample_o <= '0;
      irq_o <= 1'b0;
    end
    else
    begin
      tx_left_low <= next_tx_left_low;
      tx_left_high <= next_tx_left_high;
      tx_right_low <= next_tx_right_low;
      tx_right_high <= next_tx_right_high;
      rx_left_low <= next_rx_left_low;
      rx_left_high <= next_rx_left_high;
      rx_right_low <= next_rx_right_low;
      rx_right_high <= next_rx_right_high;
      irq_enables <= next_irq_enables;
      cpu_rdata_o <= next_cpu_rdata;
      dma_rdata_o <= next_dma_rdata;
      cpu_ack_o <= cpu_sel_i;
      dma_ack_o <= dma_sel_i;
      // RL4: sample word halves joined
      tx_sample_o <= '{left: {next_tx_left_high, next_tx_left_low}, right: {next_tx_right_high, next_tx_right_low}};
      // RL15: stereo tx gate
      // RL16: mono tx gate
      // RL17: rx gates per mode
      // RL23: flag and enable coincide
      irq_o <= |(irq_flags & irq_enables);
    end
  end
endmodule

//--- test/isr_regs_asserts.sv
// checker: bus answers, flag reads and holder loads of the data/irq bank
`timescale 1ns/1ps
module isr_regs_asserts
  import isr_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic cpu_sel_i,
  input wire logic cpu_we_i,
  input wire logic [3:0] cpu_addr_i,
  input wire logic [15:0] cpu_rdata_o,
  input wire logic cpu_ack_o,
  input wire logic dma_sel_i,
  input wire logic dma_we_i,
  input wire logic [1:0] dma_chan_i,
  input wire logic [31:0] dma_rdata_o,
  input wire logic dma_ack_o,
  input wire logic mono_i,
  input wire isr_events_s events_i,
  input wire isr_pair_s rx_sample_i,
  input wire logic rx_load_i
);
  logic rd_fl;
  logic dma_rd_rxl;
  assign rd_fl = cpu_sel_i && !cpu_we_i && cpu_addr_i == ISR_IDX_IRQ_FLAGS;
  assign dma_rd_rxl = dma_sel_i && !dma_we_i && dma_chan_i == ISR_DMA_RX_LEFT;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  cpu_ack_a: assert property (cpu_sel_i |=> cpu_ack_o)
    else $error("cpu ack missing");
  dma_ack_a: assert property (dma_sel_i ##1 !dma_sel_i |-> dma_ack_o ##1 !dma_ack_o)
    else $error("dma ack not one pulse");
  rsvd_zero_a: assert property (cpu_sel_i && !cpu_we_i && cpu_addr_i[3:1] == 3'h2
    |=> cpu_rdata_o[15:6] == 10'h000) else $error("reserved bits not zero");
  flag_clear_a: assert property (rd_fl && events_i == 4'h0 ##1 rd_fl |=> cpu_rdata_o == 16'h0000)
    else $error("flags survive a read");
  stereo_tx_a: assert property (events_i.tx_need && !mono_i ##1 rd_fl |=> cpu_rdata_o[5])
    else $error("stereo tx flag missing");
  mono_tx_a: assert property (events_i.tx_need && mono_i ##1 rd_fl |=> cpu_rdata_o[4])
    else $error("mono tx flag missing");
  frame_err_a: assert property (events_i.frame_err ##1 rd_fl |=> cpu_rdata_o[1])
    else $error("frame error flag missing");
  stereo_rx_a: assert property (events_i.rx_ready && !mono_i ##1 rd_fl |=> cpu_rdata_o[3])
    else $error("stereo rx flag missing");
  mono_rx_a: assert property (events_i.rx_ready && mono_i ##1 rd_fl |=> cpu_rdata_o[2])
    else $error("mono rx flag missing");
  over_under_a: assert property (events_i.over_under ##1 rd_fl |=> cpu_rdata_o[0])
    else $error("over or under run flag missing");
  rx_hold_a: assert property (rx_load_i && !cpu_sel_i && !dma_sel_i ##1 dma_rd_rxl
    |=> dma_rdata_o == $past(rx_sample_i.left, 2)) else $error("rx left word wrong");
endmodule
bind isr_regs isr_regs_asserts u_chk (.clock_i(clock_i), .rst_n_i(rst_n_i), .cpu_sel_i(cpu_sel_i),
  .cpu_we_i(cpu_we_i), .cpu_addr_i(cpu_addr_i), .cpu_rdata_o(cpu_rdata_o), .cpu_ack_o(cpu_ack_o),
  .dma_sel_i(dma_sel_i), .dma_we_i(dma_we_i), .dma_chan_i(dma_chan_i), .dma_rdata_o(dma_rdata_o),
  .dma_ack_o(dma_ack_o), .mono_i(mono_i), .events_i(events_i), .rx_sample_i(rx_sample_i),
  .rx_load_i(rx_load_i));

//--- test/isr_dma_model.sv
// partner model: dma controller moving whole 32-bit words
`timescale 1ns/1ps
module isr_dma_model
  import isr_pkg::*;
(
  input wire logic clock_i,
  input wire logic dma_ack_i,
  input wire logic [31:0] dma_rdata_i,
  output logic dma_sel_o,
  output logic dma_we_o,
  output logic [1:0] dma_chan_o,
  output logic [31:0] dma_wdata_o
);
  initial
  begin
    dma_sel_o = 1'b0;
    dma_we_o = 1'b0;
    dma_chan_o = 2'h0;
    dma_wdata_o = 32'h00000000;
  end
  // released data is inverted so a stale word never looks valid
  task xfer(input logic we, input logic [1:0] ch, input logic [31:0] wd, output logic [31:0] rd);
    @(negedge clock_i);
    dma_sel_o = 1'b1;
    dma_we_o = we;
    dma_chan_o = ch;
    dma_wdata_o = wd;
    // ack and read data stand for the whole cycle after the taking edge
    @(negedge clock_i);
    rd = (dma_ack_i === 1'b1) ? dma_rdata_i : ~dma_rdata_i;
    dma_sel_o = 1'b0;
    dma_chan_o = ~ch;
    dma_wdata_o = ~wd;
  endtask
endmodule

//--- test/testbench.sv
// testbench: holders, flags, enables and irq of the data/irq bank
`timescale 1ns/1ps
module testbench
  import isr_pkg::*;
;
  logic clock_i, rst_n_i, cpu_sel_i, cpu_we_i, mono_i, rx_load_i;
  logic cpu_ack_o, dma_sel_i, dma_we_i, dma_ack_o, irq_o;
  logic [3:0] cpu_addr_i;
  logic [15:0] cpu_wdata_i, cpu_rdata_o, q;
  logic [1:0] dma_chan_i;
  logic [31:0] dma_wdata_i, dma_rdata_o, rd;
  isr_events_s events_i;
  isr_pair_s rx_sample_i, tx_sample_o;
  int fails, n_compared, cyc;
  isr_regs dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .cpu_sel_i(cpu_sel_i), .cpu_we_i(cpu_we_i),
    .cpu_addr_i(cpu_addr_i), .cpu_wdata_i(cpu_wdata_i), .cpu_rdata_o(cpu_rdata_o), .cpu_ack_o(cpu_ack_o),
    .dma_sel_i(dma_sel_i), .dma_we_i(dma_we_i), .dma_chan_i(dma_chan_i), .dma_wdata_i(dma_wdata_i),
    .dma_rdata_o(dma_rdata_o), .dma_ack_o(dma_ack_o), .mono_i(mono_i), .events_i(events_i),
    .rx_sample_i(rx_sample_i), .rx_load_i(rx_load_i), .tx_sample_o(tx_sample_o), .irq_o(irq_o));
  isr_dma_model u_dma (.clock_i(clock_i), .dma_ack_i(dma_ack_o), .dma_rdata_i(dma_rdata_o),
    .dma_sel_o(dma_sel_i), .dma_we_o(dma_we_i), .dma_chan_o(dma_chan_i), .dma_wdata_o(dma_wdata_i));
  task check(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task cpu(input logic we, input logic [3:0] a, input logic [15:0] d);
    @(negedge clock_i);
    cpu_sel_i = 1'b1;
    cpu_we_i = we;
    cpu_addr_i = a;
    cpu_wdata_i = d;
    @(negedge clock_i);
    check(cpu_ack_o, 1'b1);
    cpu_sel_i = 1'b0;
    cpu_wdata_i = ~d;
    q = cpu_rdata_o;
  endtask
  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task t_reset;
    logic [3:0] idx [10];
    idx = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9, 4'hA, 4'hB};
    foreach (idx[i])
    begin
      cpu(1'b0, idx[i], 16'h0000);
      check(q, 16'h0000);
    end
    $display("reset values done");
  endtask
  task t_tx;
    logic [15:0] v [4];
    v = '{16'hFFFF, 16'h1234, 16'h0001, 16'hABCD};
    for (int i = 0; i < 4; i++)
      cpu(1'b1, 4'(i), v[i]);
    for (int i = 0; i < 4; i++)
    begin
      cpu(1'b0, 4'(i), 16'h0000);
      check(q, v[i]);
    end
    check(tx_sample_o, {v[1], v[0], v[3], v[2]});
    u_dma.xfer(1'b0, ISR_DMA_TX_LEFT, 32'h0, rd);
    check(rd, {v[1], v[0]});
    u_dma.xfer(1'b1, ISR_DMA_TX_RIGHT, 32'h5A5AC3C3, rd);
    cpu(1'b0, ISR_IDX_TX_RIGHT_LOW, 16'h0000);
    check(q, 16'hC3C3);
    cpu(1'b0, ISR_IDX_TX_RIGHT_HIGH, 16'h0000);
    check(q, 16'h5A5A);
    cpu(1'b1, 4'h6, 16'hFFFF);
    cpu(1'b0, 4'h6, 16'h0000);
    check(q, 16'h0000);
    cpu(1'b1, ISR_IDX_IRQ_FLAGS, 16'hFFFF);
    cpu(1'b0, ISR_IDX_IRQ_FLAGS, 16'h0000);
    check(q, 16'h0000);
    cpu(1'b1, ISR_IDX_TX_LEFT_LOW, 16'h2468);
    cpu(1'b1, ISR_IDX_TX_LEFT_HIGH, 16'h1357);
    check(tx_sample_o, {16'h1357, 16'h2468, 16'h5A5A, 16'hC3C3});
    $display("tx holders done");
  endtask
  task t_flags;
    logic [3:0] ev [6];
    logic [5:0] mo;
    logic iq;
    ev = '{4'h8, 4'h8, 4'h4, 4'h4, 4'h2, 4'h1};
    mo = 6'b101010;
    // the third pass masks only the flag under test, so a misrouted enable shows
    for (int e = 0; e < 3; e++)
    begin
      cpu(1'b1, ISR_IDX_IRQ_ENABLES, e ? 16'hFFFF : 16'h0000);
      cpu(1'b0, ISR_IDX_IRQ_ENABLES, 16'h0000);
      check(q, e ? 16'h003F : 16'h0000);
      for (int k = 0; k < 6; k++)
      begin
        if (e == 2)
          cpu(1'b1, ISR_IDX_IRQ_ENABLES, 16'h003F ^ (16'h0001 << (5 - k)));
        @(negedge clock_i);
        mono_i = mo[k];
        events_i = ev[k];
        @(negedge clock_i);
        events_i = 4'h0;
        cpu_sel_i = 1'b1;
        cpu_we_i = 1'b0;
        cpu_addr_i = ISR_IDX_IRQ_FLAGS;
        @(negedge clock_i);
        q = cpu_rdata_o;
        // irq is registered one cycle behind the flag, so it still stands after the read has cleared it
        iq = irq_o;
        @(negedge clock_i);
        cpu_sel_i = 1'b0;
        check(q, 16'h0001 << (5 - k));
        check(cpu_rdata_o, 16'h0000);
        check(iq, e == 1);
        check(irq_o, 1'b0);
      end
    end
    $display("flags and enables done");
  endtask
  task t_rx;
    logic [15:0] r [4];
    r = '{16'h4321, 16'h8765, 16'h0BA9, 16'hFEDC};
    rx_sample_i = {32'h87654321, 32'hFEDC0BA9};
    @(negedge clock_i);
    rx_load_i = 1'b1;
    fork
      u_dma.xfer(1'b0, ISR_DMA_RX_LEFT, 32'h0, rd);
      begin
        @(negedge clock_i);
        rx_load_i = 1'b0;
        rx_sample_i = ~rx_sample_i;
      end
    join
    check(rd, 32'h87654321);
    u_dma.xfer(1'b0, ISR_DMA_RX_RIGHT, 32'h0, rd);
    check(rd, 32'hFEDC0BA9);
    for (int i = 0; i < 4; i++)
    begin
      cpu(1'b0, 4'(i + 8), 16'h0000);
      check(q, r[i]);
    end
    cpu(1'b1, ISR_IDX_RX_LEFT_LOW, 16'h00FF);
    cpu(1'b0, ISR_IDX_RX_LEFT_LOW, 16'h0000);
    check(q, 16'h00FF);
    $display("rx holders done");
  endtask
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // bound well above the roughly 175 cycles the tests need
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      give_verdict;
    end
  end
  initial
  begin
    rst_n_i = 1'b0;
    cpu_sel_i = 1'b0;
    cpu_we_i = 1'b0;
    cpu_addr_i = 4'h0;
    cpu_wdata_i = 16'h0000;
    mono_i = 1'b0;
    rx_load_i = 1'b0;
    events_i = 4'h0;
    rx_sample_i = 64'h0;
    repeat (6) @(negedge clock_i);
    rst_n_i = 1'b1;
    t_reset;
    t_tx;
    t_flags;
    t_rx;
    give_verdict;
  end
endmodule
